// [rtl/epi_pkg.sv]
// Purpose: constants for the external pin interrupt unit
// Assumes: Avalon-MM word addressing, one 32-bit word per register
// Notes: register data is 8 bits wide in the low byte
package epi_pkg;
	localparam logic [1:0] ADDR_SENSE = 2'h0;
	localparam logic [1:0] ADDR_ENABLE = 2'h1;
	localparam logic [1:0] ADDR_FLAGS = 2'h2;
	localparam logic [1:0] ADDR_STATUS = 2'h3;
	localparam int P1_SENSE_HI = 3;
	localparam int P1_SENSE_LO = 2;
	localparam int P0_SENSE_HI = 1;
	localparam int P0_SENSE_LO = 0;
	localparam int P1_BIT = 7;
	localparam int P0_BIT = 6;
	localparam logic [7:0] SENSE_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [1:0] MODE_LOW = 2'h0;
	localparam logic [1:0] MODE_ANY = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	localparam logic [1:0] MODE_RISE = 2'h3;
	localparam logic [7:0] ENABLE_MASK = 8'hc0;
	localparam logic [7:0] SENSE_MASK = 8'h0f;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// [rtl/epi_unit.sv]
// Purpose: two-pin external interrupt unit with Avalon-MM registers
// Assumes: pins synchronous to i_clk; i_io_clk_en marks I/O clock running
// Notes: low-level request is combinational from the raw pin
`timescale 1ns/1ps
`default_nettype none

// Operation
// - pin activity triggers even when driven output
// - low level requests while pin stays low
// - edges need I/O clock; level asynchronous
// - only level requests wake from deep sleep
// - wake level sampled twice by slow clock
// - wake kept, interrupt dropped if level vanishes
// - pin one sense field bits 3:2
// - pin zero sense field bits 1:0
// - sample pin before edge detect
// - enable bit 7 gates pin one request
// - enable bit 6 gates pin zero request
// - flag bit 7 set by pin one event
// - flag bit 6 set by pin zero event
// - flag, enable, global enable dispatch vector
// - level mode holds flag cleared
module epi_unit (
	input wire logic i_clk, // system clock
	input wire logic i_srst, // synchronous reset, active high
	input wire logic [1:0] i_avs_address, // word address
	input wire logic i_avs_read, // read request
	input wire logic i_avs_write, // write request
	input wire logic [31:0] i_avs_writedata, // write data
	input wire logic [3:0] i_avs_byteenable, // byte lanes
	output logic [31:0] o_avs_readdata, // read data
	output logic o_avs_waitrequest, // stall
	input wire logic i_ext_irq_pin_zero, // pin 0 level
	input wire logic i_ext_irq_pin_one, // pin 1 level
	input wire logic i_io_clk_en, // I/O clock running
	input wire logic i_wdt_tick, // watchdog oscillator tick
	input wire logic i_global_ie, // global interrupt enable
	input wire logic i_startup_done, // start-up time ended
	input wire logic i_sleep_deep, // deep sleep (not idle)
	input wire logic [1:0] i_vector_ack, // routine entry per pin
	output logic [1:0] o_vector_req, // vector request per pin
	output logic o_wake, // wake from deep sleep
	output logic o_irq // any request
);

	typedef struct packed {
		logic [7:0] sense;
		logic [7:0] enable;
		logic [1:0] flag;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] prev;
		logic [1:0] wdt_s1;
		logic [1:0] wdt_s2;
		logic wake;
		logic [1:0] lvl_ok;
		logic ack;
		logic [31:0] rdata;
	} epi_state_type;

	epi_state_type st_q;
	epi_state_type st_d;

	logic [1:0] pins;
	logic [1:0] mode [2];
	logic [1:0] edge_hit;
	logic [1:0] lvl_req;
	logic [1:0] en_bit;
	logic [1:0] w1c;
	logic wr_flags;
	logic wr_lane0;

	function automatic logic sense_hit(input logic [1:0] m,
		input logic cur, input logic old);
		case (m)
			epi_pkg::MODE_ANY: sense_hit = cur ^ old;
			epi_pkg::MODE_FALL: sense_hit = old & ~cur;
			epi_pkg::MODE_RISE: sense_hit = cur & ~old;
			default: sense_hit = 1'b0;
		endcase
	endfunction

	// ************************************************
	// pin detection
	// ************************************************
	// pin value read straight from the pad, so driving it works
	assign pins = {i_ext_irq_pin_one, i_ext_irq_pin_zero};
	assign mode[1] = st_q.sense[epi_pkg::P1_SENSE_HI:epi_pkg::P1_SENSE_LO];
	assign mode[0] = st_q.sense[epi_pkg::P0_SENSE_HI:epi_pkg::P0_SENSE_LO];
	assign en_bit = {st_q.enable[epi_pkg::P1_BIT],
		st_q.enable[epi_pkg::P0_BIT]};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pin
			// compare synchronised samples only
			assign edge_hit[g] = i_io_clk_en &
				sense_hit(mode[g], st_q.sync2[g], st_q.prev[g]);
			// level request needs no clock, raw pin low
			assign lvl_req[g] = (mode[g] == epi_pkg::MODE_LOW) & ~pins[g];
		end
	endgenerate

	// ************************************************
	// bus decode
	// ************************************************
	// a write lands only at the edge where waitrequest is low
	assign wr_lane0 = i_avs_write & i_avs_byteenable[0] & st_q.ack;
	assign wr_flags = wr_lane0 & (i_avs_address == epi_pkg::ADDR_FLAGS);
	assign w1c = wr_flags ? {i_avs_writedata[epi_pkg::P1_BIT],
		i_avs_writedata[epi_pkg::P0_BIT]} : 2'b00;

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		st_d = st_q;
		st_d.sync1 = pins;
		st_d.sync2 = st_q.sync1;
		if (i_io_clk_en) begin
			st_d.prev = st_q.sync2;
		end
		// two watchdog samples of the level request
		if (i_wdt_tick) begin
			st_d.wdt_s1 = lvl_req;
			st_d.wdt_s2 = st_q.wdt_s1;
		end
		// only level detection may wake from deep sleep
		if (i_sleep_deep & |(st_q.wdt_s1 & st_q.wdt_s2 & en_bit)) begin
			st_d.wake = 1'b1;
			st_d.lvl_ok = st_q.wdt_s1 & st_q.wdt_s2 & en_bit;
		end else if (!i_sleep_deep) begin
			st_d.wake = 1'b0;
		end
		// level gone before start-up end: wake stays, no request
		if (st_q.wake & ~i_startup_done) begin
			st_d.lvl_ok = st_q.lvl_ok & lvl_req;
		end
		// hardware clear, write-one clear, set wins over clear
		st_d.flag = (st_q.flag & ~i_vector_ack & ~w1c) | edge_hit;
		// flag held cleared in level mode
		for (int i = 0; i < 2; i++) begin
			if (mode[i] == epi_pkg::MODE_LOW) begin
				st_d.flag[i] = 1'b0;
			end
		end
		st_d.ack = (i_avs_read | i_avs_write) & ~st_q.ack;
		if (wr_lane0) begin
			if (i_avs_address == epi_pkg::ADDR_SENSE) begin
				st_d.sense = i_avs_writedata[7:0] & epi_pkg::SENSE_MASK;
			end else if (i_avs_address == epi_pkg::ADDR_ENABLE) begin
				st_d.enable = i_avs_writedata[7:0] & epi_pkg::ENABLE_MASK;
			end
		end
		st_d.rdata = epi_pkg::UNMAPPED_READ;
		if (i_avs_address == epi_pkg::ADDR_SENSE) begin
			st_d.rdata[7:0] = st_q.sense;
		end else if (i_avs_address == epi_pkg::ADDR_ENABLE) begin
			st_d.rdata[7:0] = st_q.enable;
		end else if (i_avs_address == epi_pkg::ADDR_FLAGS) begin
			st_d.rdata[epi_pkg::P1_BIT] = st_q.flag[1];
			st_d.rdata[epi_pkg::P0_BIT] = st_q.flag[0];
		end else if (i_avs_address == epi_pkg::ADDR_STATUS) begin
			st_d.rdata[1:0] = o_vector_req;
			st_d.rdata[2] = st_q.wake;
			st_d.rdata[4:3] = st_q.lvl_ok;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_q <= '0;
			st_q.sense <= epi_pkg::SENSE_RESET;
			st_q.enable <= epi_pkg::ENABLE_RESET;
			st_q.flag <= epi_pkg::FLAGS_RESET[7:6];
		end else begin
			st_q <= st_d;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	// flag or level, with enable and global enable
	assign o_vector_req = ((st_q.flag | lvl_req) & en_bit) &
		{2{i_global_ie}};
	assign o_irq = |o_vector_req;
	assign o_wake = st_q.wake;
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~st_q.ack;
	assign o_avs_readdata = st_q.rdata;

endmodule // epi_unit

`default_nettype wire

// [dv/epi_monitor.sv]
// Purpose: port checks for epi_unit
// Assumes: one clock, synchronous reset
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module epi_monitor (
	input wire logic i_clk, // clock
	input wire logic i_srst, // reset
	input wire logic [1:0] i_avs_address, // address
	input wire logic i_avs_read, // read
	input wire logic i_avs_write, // write
	input wire logic [31:0] o_avs_readdata, // read data
	input wire logic o_avs_waitrequest, // stall
	input wire logic i_global_ie, // global enable
	input wire logic i_sleep_deep, // deep sleep
	input wire logic [1:0] o_vector_req, // requests
	input wire logic o_wake, // wake
	input wire logic o_irq // irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence s_pend;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	sequence s_rd;
		i_avs_read && !o_avs_waitrequest;
	endsequence
	a_irq_or: assert property (o_irq == |o_vector_req)
		else $error("irq not the or of requests");
	a_gie_gate: assert property (!i_global_ie |-> o_vector_req == 2'h0)
		else $error("request without global enable");
	a_wait_one: assert property (s_pend |=> !o_avs_waitrequest)
		else $error("stall longer than one cycle");
	a_idle_ready: assert property (!(i_avs_read || i_avs_write)
		|-> !o_avs_waitrequest) else $error("stall while idle");
	a_rsv_sense: assert property (s_rd ##0 i_avs_address == 2'h0
		|-> o_avs_readdata[31:4] == 28'h0) else $error("sense bits");
	a_rsv_enable: assert property (s_rd ##0 i_avs_address == 2'h1
		|-> o_avs_readdata[5:0] == 6'h0) else $error("enable bits");
	a_wake_drop: assert property (!i_sleep_deep |=> !o_wake)
		else $error("wake outside deep sleep");
	a_wake_cause: assert property ($rose(o_wake) |-> $past(i_sleep_deep))
		else $error("wake rose without sleep");
endmodule // epi_monitor
bind epi_unit epi_monitor u_mon (.i_clk, .i_srst, .i_avs_address,
	.i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
	.i_global_ie, .i_sleep_deep, .o_vector_req, .o_wake, .o_irq);
`default_nettype wire

// [dv/epi_pin_src.sv]
// Purpose: external sources on the two pins
// Assumes: bench gives the wanted levels
// Notes: levels change just after an edge
`timescale 1ns/1ps
`default_nettype none
module epi_pin_src (
	input wire logic i_clk, // clock
	input wire logic [1:0] i_lvl, // wanted levels
	output logic [1:0] o_pin // pin one, pin zero
);
	// a level is held until told otherwise
	always_ff @(posedge i_clk) begin
		o_pin <= i_lvl;
	end
endmodule // epi_pin_src
`default_nettype wire

// [dv/tb.sv]
// Purpose: self-checking bench for epi_unit
// Assumes: 100 MHz clock, pins from epi_pin_src
// Notes: flags are read over the bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t got %h", $time, a); end end
module tb;
	logic i_clk = 1'h0, i_srst = 1'h1, rd = 1'h0, wr = 1'h0, io = 1'h1;
	logic wdt = 1'h0, gie = 1'h0, slp = 1'h0, ws, wake, irq;
	logic su = 1'h1;
	logic [1:0] ad = 2'h0, ack = 2'h0, lvl = 2'h3, pin, req;
	logic [31:0] wd = 32'h0, rq, rdata;
	int error_cnt = 0, tests_run = 0;
	epi_pin_src u_src (.i_clk, .i_lvl(lvl), .o_pin(pin));
	epi_unit u_dut (.i_clk, .i_srst, .i_avs_address(ad), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdata), .o_avs_waitrequest(ws),
		.i_ext_irq_pin_zero(pin[0]), .i_ext_irq_pin_one(pin[1]),
		.i_io_clk_en(io), .i_wdt_tick(wdt), .i_global_ie(gie),
		.i_startup_done(su), .i_sleep_deep(slp), .i_vector_ack(ack),
		.o_vector_req(req), .o_wake(wake), .o_irq(irq));
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge i_clk);
	endtask
	task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
		int n;
		logic busy;
		@(posedge i_clk);
		rd <= !w;
		wr <= w;
		ad <= a;
		wd <= {24'h0, d};
		n = 0;
		busy = 1'h1;
		// waitrequest and read data are read mid-cycle, settled
		while (busy && n < 20) begin
			@(negedge i_clk);
			busy = (ws !== 1'h0);
			rq = rdata;
			@(posedge i_clk);
			n++;
		end
		rd <= 1'h0;
		wr <= 1'h0;
		if (busy) begin
			error_cnt++;
			tally_and_finish;
		end
	endtask
	task automatic chk(input logic [1:0] a, input logic [7:0] e);
		bus(1'h0, a, 8'h00);
		`CHK(rq[7:0], e)
	endtask
	task automatic t_regs;
		for (int a = 0; a < 4; a++) chk(2'(a), 8'h00);
		bus(1'h1, 2'h0, 8'hff);
		chk(2'h0, 8'h0f);
	endtask
	task automatic t_edges;
		for (int m = 1; m < 4; m++) begin
			bus(1'h1, 2'h0, 8'(m * 5));
			bus(1'h1, 2'h2, 8'hc0);
			lvl <= 2'h0;
			cyc(6);
			chk(2'h2, (m != 3) ? 8'hc0 : 8'h00);
			bus(1'h1, 2'h2, 8'hc0);
			lvl <= 2'h3;
			cyc(6);
			chk(2'h2, (m != 2) ? 8'hc0 : 8'h00);
		end
		bus(1'h1, 2'h2, 8'hc0);
		io <= 1'h0;
		lvl <= 2'h0;
		cyc(6);
		lvl <= 2'h3;
		cyc(6);
		chk(2'h2, 8'h00);
		io <= 1'h1;
	endtask
	task automatic t_ack;
		bus(1'h1, 2'h0, 8'h0a);
		bus(1'h1, 2'h1, 8'hc0);
		gie <= 1'h1;
		lvl <= 2'h2;
		cyc(6);
		`CHK(req, 2'h1)
		ack <= 2'h1;
		cyc(1);
		ack <= 2'h0;
		chk(2'h2, 8'h00);
	endtask
	task automatic t_level;
		bus(1'h1, 2'h0, 8'h00);
		lvl <= 2'h1;
		cyc(3);
		`CHK(req, 2'h2)
		chk(2'h2, 8'h00);
		su <= 1'h0;
		slp <= 1'h1;
		repeat (2) begin
			cyc(2);
			wdt <= 1'h1;
			cyc(1);
			wdt <= 1'h0;
		end
		cyc(3);
		`CHK(wake, 1'h1)
		`CHK(irq, 1'h1)
		chk(2'h3, 8'h16);
		lvl <= 2'h3;
		cyc(4);
		chk(2'h3, 8'h04);
		slp <= 1'h0;
		su <= 1'h1;
		gie <= 1'h0;
	endtask
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		cyc(16);
		i_srst <= 1'h0;
		t_regs;
		t_edges;
		t_ack;
		t_level;
		tally_and_finish;
	end
endmodule // tb
`default_nettype wire
